/* verilog/tiru_top.sv */
// Trigger input response unit: APB registers, five line detectors and channel response logic
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "tiru_regs.svh"

module tiru_top
    import tiru_pkg::*;
#(
    parameter int NUM_LINES = 5,
    parameter int NUM_CHANS = 4
)
(
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`TIRU_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Trigger lines
    input  wire logic                   trigger_line_0,
    input  wire logic                   trigger_line_1,
    input  wire logic                   trigger_line_2,
    input  wire logic                   trigger_line_3,
    input  wire logic                   trigger_line_4,
    // Channel on/off
    output logic                        output_channel_a_on,
    output logic                        output_channel_b_on,
    output logic                        output_channel_c_on,
    output logic                        output_channel_d_on,
    // Channel operating modes
    output tiru_mode_e                  output_channel_a_mode,
    output tiru_mode_e                  output_channel_b_mode,
    output tiru_mode_e                  output_channel_c_mode,
    output tiru_mode_e                  output_channel_d_mode,
    output tiru_pair_e                  pair_mode
);

    localparam int LIDX_W = 3;

    // Register state
    tiru_line_cfg_s           line_cfg_q [NUM_LINES];
    logic [NUM_CHANS-1:0]     chan_on_q;
    logic [NUM_CHANS-1:0]     chan_on_d;
    tiru_mode_e               chan_mode_q [NUM_CHANS];
    tiru_mode_e               chan_mode_d [NUM_CHANS];
    tiru_pair_e               pair_q;
    tiru_pair_e               pair_d;
    logic [NUM_LINES-1:0]     fired_q;
    logic [NUM_LINES-1:0]     fired_d;
    logic [31:0]              prdata_q;
    logic                     pslverr_q;

    // Detector results
    logic [NUM_LINES-1:0]     fire_w;
    logic [NUM_LINES-1:0]     level_w;
    logic [NUM_LINES-1:0]     line_w;

    // Bus decode
    logic                     setup_w;
    logic                     wr_w;
    logic [LIDX_W-1:0]        line_idx_w;
    logic                     sel_line_w;
    logic                     sel_ctrl_w;
    logic                     sel_mode_w;
    logic                     sel_stat_w;
    logic                     mapped_w;
    logic [31:0]              line_rd_w;
    logic [31:0]              ctrl_rd_w;
    logic [31:0]              mode_rd_w;
    logic [31:0]              stat_rd_w;
    logic [31:0]              rd_w;
    logic [2*NUM_CHANS-1:0]   mode_flat_w;
    tiru_line_cfg_s           wr_cfg_w;

    assign line_w = {trigger_line_4, trigger_line_3, trigger_line_2, trigger_line_1, trigger_line_0};

    assign setup_w    = psel & ~penable;
    assign wr_w       = psel & penable & pwrite;
    assign line_idx_w = paddr[LIDX_W+1:2];
    assign sel_line_w = (paddr[`TIRU_ADDR_W-1:LIDX_W+2] == '0) && (paddr[1:0] == 2'h0)
                        && (32'(line_idx_w) < NUM_LINES);
    assign sel_ctrl_w = (paddr == `TIRU_OFF_CHAN_CTRL);
    assign sel_mode_w = (paddr == `TIRU_OFF_CHAN_MODE);
    assign sel_stat_w = (paddr == `TIRU_OFF_LINE_STAT);
    assign mapped_w   = sel_line_w | sel_ctrl_w | sel_mode_w | sel_stat_w;
    assign wr_cfg_w   = tiru_line_cfg_s'(pwdata[`TIRU_CFG_W-1:0]);

    // Per-line detectors
    generate
        for (genvar g = 0; g < NUM_LINES; g++)
        begin : g_line
            tiru_det_if u_if ();

            assign u_if.en    = line_cfg_q[g].en;
            assign u_if.ttype = line_cfg_q[g].ttype;
            assign u_if.sens  = line_cfg_q[g].sens;
            assign fire_w[g]  = u_if.fire;
            assign level_w[g] = u_if.level;

            tiru_detect u_det
            (
                .mclk    (mclk),
                .rst     (rst),
                .line_in (line_w[g]),
                .det     (u_if.det)
            );
        end
        for (genvar c = 0; c < NUM_CHANS; c++)
        begin : g_flat
            assign mode_flat_w[2*c+1:2*c] = chan_mode_q[c];
        end
    endgenerate

    // Read data sources
    assign line_rd_w = sel_line_w ? 32'(line_cfg_q[line_idx_w]) : 32'h0;
    assign ctrl_rd_w = 32'(chan_on_q);
    assign mode_rd_w = 32'(mode_flat_w) | (32'(pair_q) << `TIRU_MODE_PAIR_LSB);
    assign stat_rd_w = (32'(level_w) << `TIRU_STAT_LEVEL_LSB) | (32'(fired_q) << `TIRU_STAT_FIRED_LSB);
    assign rd_w      = sel_line_w ? line_rd_w :
                       sel_ctrl_w ? ctrl_rd_w :
                       sel_mode_w ? mode_rd_w :
                       sel_stat_w ? stat_rd_w : 32'h0;

    // Channel state: software write first, then line responses in line order
    always_comb
    begin
        chan_on_d = chan_on_q;
        pair_d    = pair_q;
        for (int c = 0; c < NUM_CHANS; c++)
            chan_mode_d[c] = chan_mode_q[c];
        if (wr_w && sel_ctrl_w)
            chan_on_d = pwdata[NUM_CHANS-1:0];
        if (wr_w && sel_mode_w)
        begin
            for (int c = 0; c < NUM_CHANS; c++)
                chan_mode_d[c] = tiru_mode_e'(pwdata[2*c +: 2]);
            pair_d = tiru_pair_e'(pwdata[`TIRU_MODE_PAIR_LSB +: 2]);
        end
        for (int i = 0; i < NUM_LINES; i++)
        begin
            if (fire_w[i])
            begin
                unique case (line_cfg_q[i].resp)
                    RESP_SWITCH_ON:
                        chan_on_d = chan_on_d | line_cfg_q[i].chans;
                    RESP_SWITCH_OFF:
                        chan_on_d = chan_on_d & ~line_cfg_q[i].chans;
                    RESP_INVERT:
                        chan_on_d = chan_on_d ^ line_cfg_q[i].chans;
                    RESP_POWER:
                        for (int c = 0; c < NUM_CHANS; c++)
                            if (line_cfg_q[i].chans[c])
                                chan_mode_d[c] = MODE_POWER;
                    RESP_LOAD_CONSTANT_VOLTAGE:
                        for (int c = 0; c < NUM_CHANS; c++)
                            if (line_cfg_q[i].chans[c])
                                chan_mode_d[c] = MODE_LOAD_CONSTANT_VOLTAGE;
                    RESP_LOAD_CONSTANT_CURRENT:
                        for (int c = 0; c < NUM_CHANS; c++)
                            if (line_cfg_q[i].chans[c])
                                chan_mode_d[c] = MODE_LOAD_CONSTANT_CURRENT;
                    RESP_LOAD_CONSTANT_RESISTANCE:
                        for (int c = 0; c < NUM_CHANS; c++)
                            if (line_cfg_q[i].chans[c])
                                chan_mode_d[c] = MODE_LOAD_CONSTANT_RESISTANCE;
                    RESP_PAIR_INDEPENDENT:
                        pair_d = PAIR_INDEPENDENT;
                    RESP_PAIR_SERIES:
                        pair_d = PAIR_SERIES;
                    RESP_PAIR_PARALLEL:
                        pair_d = PAIR_PARALLEL;
                    default:
                        chan_on_d = chan_on_d;
                endcase
            end
        end
    end

    // Sticky fired flags, write one to clear, new event wins
    assign fired_d = (fired_q & ~((wr_w && sel_stat_w) ? pwdata[`TIRU_STAT_FIRED_LSB +: NUM_LINES]
                                                       : {NUM_LINES{1'b0}})) | fire_w;

    // Line configuration registers
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NUM_LINES; i++)
        begin
            if (rst)
                line_cfg_q[i] <= tiru_line_cfg_s'(`TIRU_CFG_RST);
            else if (wr_w && sel_line_w && (32'(line_idx_w) == i))
                line_cfg_q[i] <= wr_cfg_w;
        end
    end

    // Channel state registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            chan_on_q <= `TIRU_CHAN_CTRL_RST;
            pair_q    <= tiru_pair_e'(`TIRU_PAIR_RST);
            fired_q   <= '0;
            for (int c = 0; c < NUM_CHANS; c++)
                chan_mode_q[c] <= tiru_mode_e'(2'h0);
        end
        else
        begin
            chan_on_q <= chan_on_d;
            pair_q    <= pair_d;
            fired_q   <= fired_d;
            for (int c = 0; c < NUM_CHANS; c++)
                chan_mode_q[c] <= chan_mode_d[c];
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end
        else if (setup_w)
        begin
            prdata_q  <= pwrite ? 32'h0 : rd_w;
            pslverr_q <= ~mapped_w;
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = pslverr_q & psel & penable;
    assign pready  = 1'b1;

    assign output_channel_a_on   = chan_on_q[0];
    assign output_channel_b_on   = chan_on_q[1];
    assign output_channel_c_on   = chan_on_q[2];
    assign output_channel_d_on   = chan_on_q[3];
    assign output_channel_a_mode = chan_mode_q[0];
    assign output_channel_b_mode = chan_mode_q[1];
    assign output_channel_c_mode = chan_mode_q[2];
    assign output_channel_d_mode = chan_mode_q[3];
    assign pair_mode             = pair_q;

endmodule // tiru_top

`default_nettype wire

/* verilog/tiru_regs.svh */
// Register offsets, reset values and filter counts of the trigger input response unit
`ifndef TIRU_REGS_SVH
`define TIRU_REGS_SVH

`define TIRU_ADDR_W          12
`define TIRU_OFF_LINE_CFG0   12'h000
`define TIRU_OFF_CHAN_CTRL   12'h020
`define TIRU_OFF_CHAN_MODE   12'h024
`define TIRU_OFF_LINE_STAT   12'h028

`define TIRU_CFG_W           14
`define TIRU_CFG_RST         14'h0000
`define TIRU_CHAN_CTRL_RST   4'h0
`define TIRU_CHAN_MODE_RST   8'h00
`define TIRU_PAIR_RST        2'h0

`define TIRU_STAT_LEVEL_LSB  0
`define TIRU_STAT_FIRED_LSB  8
`define TIRU_MODE_PAIR_LSB   8

`define TIRU_FILT_W          5
`define TIRU_FILT_LOW        5'h10
`define TIRU_FILT_MID        5'h04
`define TIRU_FILT_HIGH       5'h01

`endif

/* verilog/tiru_pkg.sv */
// Types of the trigger input response unit
`default_nettype none

package tiru_pkg;

    typedef enum logic [2:0] {
        TYPE_RISE,
        TYPE_FALL,
        TYPE_HIGH,
        TYPE_LOW,
        TYPE_STATE
    } tiru_type_e;

    typedef enum logic [1:0] {
        SENS_LOW,
        SENS_MID,
        SENS_HIGH
    } tiru_sens_e;

    typedef enum logic [3:0] {
        RESP_SWITCH_ON,
        RESP_SWITCH_OFF,
        RESP_INVERT,
        RESP_POWER,
        RESP_LOAD_CONSTANT_VOLTAGE,
        RESP_LOAD_CONSTANT_CURRENT,
        RESP_LOAD_CONSTANT_RESISTANCE,
        RESP_PAIR_INDEPENDENT,
        RESP_PAIR_SERIES,
        RESP_PAIR_PARALLEL
    } tiru_resp_e;

    typedef enum logic [1:0] {
        MODE_POWER,
        MODE_LOAD_CONSTANT_VOLTAGE,
        MODE_LOAD_CONSTANT_CURRENT,
        MODE_LOAD_CONSTANT_RESISTANCE
    } tiru_mode_e;

    typedef enum logic [1:0] {
        PAIR_INDEPENDENT,
        PAIR_SERIES,
        PAIR_PARALLEL
    } tiru_pair_e;

    typedef struct packed {
        tiru_resp_e resp;
        logic [3:0] chans;
        tiru_sens_e sens;
        tiru_type_e ttype;
        logic       en;
    } tiru_line_cfg_s;

endpackage

`default_nettype wire

/* verilog/tiru_det_if.sv */
// Link between the control core and one line detector
`timescale 1ns/1ns
`default_nettype none

interface tiru_det_if;
    import tiru_pkg::*;
    logic       en;
    tiru_type_e ttype;
    tiru_sens_e sens;
    logic       fire;
    logic       level;

    modport det
    (
        input  en,
        input  ttype,
        input  sens,
        output fire,
        output level
    );

    modport ctl
    (
        output en,
        output ttype,
        output sens,
        input  fire,
        input  level
    );
endinterface

`default_nettype wire

/* verilog/tiru_detect.sv */
// Synchroniser, sensitivity filter and condition detector for one trigger line
`timescale 1ns/1ns
`default_nettype none
`include "tiru_regs.svh"

module tiru_detect
    import tiru_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Raw line
    input  wire logic line_in,
    // Core side
    tiru_det_if.det   det
);

    logic                   sync1_q;
    logic                   sync2_q;
    logic                   filt_q;
    logic                   filt_d;
    logic                   prev_q;
    logic                   cond_prev_q;
    logic [`TIRU_FILT_W-1:0] cnt_q;
    logic [`TIRU_FILT_W-1:0] cnt_d;
    logic [`TIRU_FILT_W-1:0] need_w;
    logic                   rise_w;
    logic                   fall_w;
    logic                   cond_w;
    logic                   is_edge_w;

    // Stable samples needed per grade
    assign need_w = (det.sens == SENS_LOW) ? `TIRU_FILT_LOW :
                    (det.sens == SENS_MID) ? `TIRU_FILT_MID : `TIRU_FILT_HIGH;

    always_comb
    begin
        filt_d = filt_q;
        cnt_d  = '0;
        if (sync2_q != filt_q)
        begin
            if (cnt_q + 1'b1 >= need_w)
                filt_d = sync2_q;
            else
                cnt_d = cnt_q + 1'b1;
        end
    end

    assign rise_w = filt_q & ~prev_q;
    assign fall_w = ~filt_q & prev_q;

    // Condition per detection type
    always_comb
    begin
        cond_w    = 1'b0;
        is_edge_w = 1'b1;
        unique case (det.ttype)
            TYPE_RISE:  cond_w = rise_w;
            TYPE_FALL:  cond_w = fall_w;
            TYPE_HIGH:
            begin
                cond_w    = filt_q;
                is_edge_w = 1'b0;
            end
            TYPE_LOW:
            begin
                cond_w    = ~filt_q;
                is_edge_w = 1'b0;
            end
            TYPE_STATE: cond_w = rise_w | fall_w;
            default:    cond_w = 1'b0;
        endcase
    end

    // One pulse per edge, one on entry into a level
    assign det.fire  = det.en & cond_w & (is_edge_w | ~cond_prev_q);
    assign det.level = filt_q;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sync1_q     <= 1'b0;
            sync2_q     <= 1'b0;
            filt_q      <= 1'b0;
            prev_q      <= 1'b0;
            cond_prev_q <= 1'b0;
            cnt_q       <= '0;
        end
        else
        begin
            sync1_q     <= line_in;
            sync2_q     <= sync1_q;
            filt_q      <= filt_d;
            prev_q      <= filt_q;
            cond_prev_q <= det.en & cond_w;
            cnt_q       <= cnt_d;
        end
    end

endmodule // tiru_detect

`default_nettype wire

/* dv/tiru_trig_src.sv */
// External trigger-line source driving the five lines
`timescale 1ns/1ns
`default_nettype none

module tiru_trig_src
(
    // Clock
    input  wire logic       mclk,
    // Lines
    output var  logic [4:0] lines
);
    initial lines = 5'h00;

    // Level change just after an edge
    task automatic drive(input int idx, input logic v);
        lines[idx] <= v;
    endtask

    // High for n cycles, then low
    task automatic pulse(input int idx, input int n);
        lines[idx] <= 1'b1;
        repeat (n) @(posedge mclk);
        lines[idx] <= 1'b0;
    endtask
endmodule // tiru_trig_src

`default_nettype wire

/* dv/tiru_assertions.sv */
// Port checks of the trigger input response unit
`timescale 1ns/1ns
`default_nettype none
`include "tiru_regs.svh"

module tiru_assertions
    import tiru_pkg::*;
(
    // Clock, reset, bus
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Lines and outputs
    input wire logic [4:0]  lines,
    input wire logic [3:0]  on_v,
    input wire tiru_mode_e  output_channel_a_mode,
    input wire tiru_pair_e  pair_mode
);
    logic [5:0]  quiet_q;
    logic [4:0]  lines_q;
    logic [13:0] cfg0_q;
    wire         acc = psel && penable;
    wire         quiet = quiet_q > 6'h28;

    // Idle time and line 0 settings
    always_ff @(posedge mclk)
    begin
        lines_q <= lines;
        if (rst || (acc && pwrite) || lines != lines_q)
            quiet_q <= 6'h00;
        else if (quiet_q != 6'h3f)
            quiet_q <= quiet_q + 6'h01;
        if (rst)
            cfg0_q <= 14'h0000;
        else if (acc && pwrite && paddr == `TIRU_OFF_LINE_CFG0)
            cfg0_q <= pwdata[13:0];
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_ctrl_wr;
        quiet && acc && pwrite && paddr == `TIRU_OFF_CHAN_CTRL;
    endsequence
    sequence s_rise0;
        $rose(lines[0]) && cfg0_q[6:0] == 7'h61;
    endsequence

    property p_reset;
        $fell(rst) |-> on_v == 4'h0 && prdata == 32'h0 && pair_mode == PAIR_INDEPENDENT
            && output_channel_a_mode == MODE_POWER;
    endproperty
    property p_ready;
        acc |-> pready;
    endproperty
    property p_err_ok;
        acc && paddr == `TIRU_OFF_LINE_CFG0 |-> !pslverr;
    endproperty
    property p_err_map;
        acc && paddr > `TIRU_OFF_LINE_STAT |-> pslverr;
    endproperty
    property p_quiet;
        quiet && !(acc && pwrite) |=> $stable(on_v) && $stable(output_channel_a_mode) && $stable(pair_mode);
    endproperty
    property p_sw_wr;
        s_ctrl_wr |=> on_v == $past(pwdata[3:0]);
    endproperty
    property p_on;
        s_rise0 ##0 cfg0_q[13:10] == 4'h0 |-> ##[2:8] on_v[0];
    endproperty
    property p_off;
        s_rise0 ##0 cfg0_q[13:10] == 4'h1 |-> ##[2:8] !on_v[0];
    endproperty

    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    a_ready: assert property (p_ready) else $error("access not answered");
    a_err_ok: assert property (p_err_ok) else $error("error on mapped address");
    a_err_map: assert property (p_err_map) else $error("no error on unmapped address");
    a_quiet: assert property (p_quiet) else $error("outputs moved without cause");
    a_sw_wr: assert property (p_sw_wr) else $error("channel write not applied");
    a_on: assert property (p_on) else $error("switch-on response missing");
    a_off: assert property (p_off) else $error("switch-off response missing");
endmodule // tiru_assertions

bind tiru_top tiru_assertions u_chk
(
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lines({trigger_line_4, trigger_line_3, trigger_line_2, trigger_line_1, trigger_line_0}),
    .on_v({output_channel_d_on, output_channel_c_on, output_channel_b_on, output_channel_a_on}),
    .output_channel_a_mode(output_channel_a_mode), .pair_mode(pair_mode)
);

`default_nettype wire

/* dv/tiru_top_tb.sv */
// Self-checking bench of the trigger input response unit
`timescale 1ns/1ns
`default_nettype none
`include "tiru_regs.svh"

module tiru_top_tb;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [4:0]  ln;
    wire  [3:0]  on_v;
    wire  [1:0]  md [4];
    wire  [1:0]  pm;
    logic [31:0] rd;
    logic        er;
    int          err_count = 0;
    int          checks_done = 0;
    int          cyc = 0;

    tiru_trig_src src (.mclk(mclk), .lines(ln));
    tiru_top uut
    (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trigger_line_0(ln[0]), .trigger_line_1(ln[1]), .trigger_line_2(ln[2]),
        .trigger_line_3(ln[3]), .trigger_line_4(ln[4]),
        .output_channel_a_on(on_v[0]), .output_channel_b_on(on_v[1]),
        .output_channel_c_on(on_v[2]), .output_channel_d_on(on_v[3]),
        .output_channel_a_mode(md[0]), .output_channel_b_mode(md[1]),
        .output_channel_c_mode(md[2]), .output_channel_d_mode(md[3]), .pair_mode(pm)
    );

    always #25 mclk = ~mclk;

    // Hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask

    // One APB transfer, then one idle edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    function automatic logic [31:0] cfg(input logic en, input logic [2:0] ty, input logic [1:0] se,
                                        input logic [3:0] ch, input logic [3:0] rs);
        return {18'h0, rs, ch, se, ty, en};
    endfunction

    task automatic idle();
        repeat (56) @(posedge mclk);
    endtask

    task automatic t_readback();
        logic [31:0] v;
        for (int i = 0; i < 5; i++)
        begin
            v = cfg(i[0], 3'(i), 2'(i % 3), 4'(i + 9) | 4'h3, 4'(i + 5));
            apb(1'b1, 12'(4 * i), v);
            apb(1'b0, 12'(4 * i), 32'h0);
            chk("line_cfg", v, rd);
            apb(1'b1, 12'(4 * i), 32'h0);
        end
        apb(1'b0, 12'h030, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
    endtask

    task automatic t_switch();
        logic [3:0] rs [4] = '{4'h0, 4'h1, 4'h2, 4'h2};
        logic [3:0] ex [4] = '{4'b0111, 4'b0010, 4'b0111, 4'b0010};
        apb(1'b1, `TIRU_OFF_CHAN_CTRL, 32'h2);
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, `TIRU_OFF_LINE_CFG0, cfg(1'b1, 3'h0, 2'h2, 4'b0101, rs[k]));
            src.pulse(0, 10);
            idle();
            chk("chan_on", {28'h0, ex[k]}, {28'h0, on_v});
        end
        apb(1'b1, `TIRU_OFF_LINE_CFG0, 32'h0);
        apb(1'b0, `TIRU_OFF_CHAN_CTRL, 32'h0);
        chk("chan_ctrl", 32'h0000_0002, rd);
        apb(1'b0, `TIRU_OFF_LINE_STAT, 32'h0);
        chk("line_stat", 32'h0000_0900, rd);
        apb(1'b1, `TIRU_OFF_LINE_STAT, 32'h0000_1f00);
        apb(1'b0, `TIRU_OFF_LINE_STAT, 32'h0);
        chk("stat_clear", 32'h0, rd);
    endtask

    task automatic t_modes();
        logic [1:0] m;
        apb(1'b1, `TIRU_OFF_CHAN_MODE, 32'h0000_02ff);
        for (int r = 3; r < 10; r++)
        begin
            m = 2'(r - 3);
            apb(1'b1, 12'h010, cfg(1'b1, 3'h0, 2'h2, (r < 7) ? 4'b1010 : 4'b0011, 4'(r)));
            src.pulse(4, 10);
            idle();
            if (r < 7)
                chk("chan_mode", {24'h0, m, 2'h3, m, 2'h3}, {24'h0, md[3], md[2], md[1], md[0]});
            else
                chk("pair_mode", 32'(r - 7), {30'h0, pm});
        end
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b0, `TIRU_OFF_CHAN_MODE, 32'h0);
        chk("mode_reg", 32'h0000_02ff, rd);
    endtask

    task automatic t_types();
        logic [4:0] up = 5'b11101;
        logic [4:0] dn = 5'b00111;
        for (int t = 0; t < 5; t++)
        begin
            apb(1'b1, `TIRU_OFF_CHAN_CTRL, 32'h0);
            apb(1'b1, 12'h004, cfg(1'b1, 3'(t), 2'h2, 4'b1000, 4'h2));
            idle();
            src.drive(1, 1'b1);
            idle();
            chk("rise_fire", {31'h0, up[t]}, {31'h0, on_v[3]});
            src.drive(1, 1'b0);
            idle();
            chk("fall_fire", {31'h0, dn[t]}, {31'h0, on_v[3]});
            apb(1'b1, 12'h004, 32'h0);
        end
    endtask

    task automatic t_sens();
        logic [3:0] ex = 4'b0110;
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, `TIRU_OFF_CHAN_CTRL, 32'h0);
            apb(1'b1, 12'h00c, cfg(k < 3, 3'h0, (k < 3) ? 2'(k) : 2'h2, 4'b0100, 4'h2));
            idle();
            src.pulse(3, 8);
            idle();
            chk("sens_fire", {31'h0, ex[k]}, {31'h0, on_v[2]});
        end
    endtask

    // Reset in mid-run clears modes, pairing and line settings
    task automatic t_reset();
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("reset_out", 32'h0, {18'h0, pm, md[3], md[2], md[1], md[0], on_v});
        apb(1'b0, `TIRU_OFF_LINE_CFG0, 32'h0);
        chk("reset_cfg", 32'h0, rd);
    endtask

    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_readback();
        t_switch();
        t_modes();
        t_types();
        t_sens();
        t_reset();
        tally_and_finish();
    end
endmodule // tiru_top_tb

`default_nettype wire
